// ==== ctu_pkg.sv ====
package ctu_pkg;

    // register byte offsets on the bus
    localparam logic [7:0]  CTL_OFS       = 8'h00;
    localparam logic [7:0]  IRQ_STAT_OFS  = 8'h04;
    localparam logic [7:0]  IRQ_MASK_OFS  = 8'h08;

    // control register field positions
    localparam int A_MODE_BIT    = 31;
    localparam int A_POL_BIT     = 30;
    localparam int A_SEL_HI      = 29;
    localparam int A_SEL_LO      = 26;
    localparam int B_FLAG_BIT    = 25;
    localparam int A_FLAG_BIT    = 24;
    localparam int B_MODE_BIT    = 23;
    localparam int B_POL_BIT     = 22;
    localparam int B_SEL_HI      = 21;
    localparam int B_SEL_LO      = 18;
    localparam int ON_BIT        = 15;
    localparam int IDLE_STOP_BIT = 13;
    localparam int DELAY_GEN_BIT = 12;
    localparam int PASS_BIT      = 11;
    localparam int ORDER_BIT     = 10;
    localparam int GROUND_BIT    = 9;
    localparam int TRIG_BIT      = 8;
    localparam int TRIM_HI       = 7;
    localparam int TRIM_LO       = 2;
    localparam int RANGE_HI      = 1;
    localparam int RANGE_LO      = 0;

    // values after reset and implemented-bit mask
    localparam logic [31:0] CTL_RST       = 32'h0000_0000;
    localparam logic [31:0] CTL_IMPL_MASK = 32'hFFFC_BFFF;
    localparam int          IRQ_W         = 2;
    localparam logic [1:0]  IRQ_STAT_RST  = 2'h0;
    localparam logic [1:0]  IRQ_MASK_RST  = 2'h0;
    localparam int          EVT_A_IDX     = 0;
    localparam int          EVT_B_IDX     = 1;
    localparam logic [31:0] RDATA_RST     = 32'h0000_0000;

    // data-phase state of the bus slave
    typedef enum logic [1:0] {
        CTU_BUS_IDLE,
        CTU_BUS_WRITE,
        CTU_BUS_READ
    } ctu_bus_t;

endpackage

// ==== ctu_sync2.sv ====
`timescale 1ns/1ps
module ctu_sync2 #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // asynchronous in, synchronised out
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    // first stage feeds only the second stage
    always_comb begin
        meta_next = din;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign dout = sync_reg;
endmodule // ctu_sync2

// ==== ctu_edge_unit.sv ====
`timescale 1ns/1ps
module ctu_edge_unit #(
    parameter int NSRC  = 16,
    parameter int SEL_W = 4
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // candidate sources and configuration
    input  wire logic [NSRC-1:0]  src,
    input  wire logic [SEL_W-1:0] sel,
    input  wire logic             mode,
    input  wire logic             pol,
    // qualifying activity this cycle
    output logic                  hit
);
    logic prev_reg;
    logic prev_next;
    logic cur;
    logic active;

    // a change of sel may look like one transition; software should
    // clear the flag after reconfiguring
    always_comb begin
        cur       = src[sel];
        active    = (cur == pol);
        prev_next = cur;
        if (mode) begin
            hit = active && (prev_reg != pol);
        end else begin
            hit = active;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
        end
    end
endmodule // ctu_edge_unit

// ==== ctu_edge_ctrl.sv ====
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module ctu_edge_ctrl (
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        SYS_RST,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // comparator results, asynchronous
    input  wire logic        CMP1_RESULT,
    input  wire logic        CMP2_RESULT,
    input  wire logic        CMP3_RESULT,
    // on-chip events, same clock
    input  wire logic        CAPTURE_UNIT_1_EVT,
    input  wire logic        CAPTURE_UNIT_2_EVT,
    input  wire logic        CAPTURE_UNIT_3_EVT,
    input  wire logic        COMPARE_UNIT_1_EVT,
    input  wire logic        FIRST_TIMER_EVENT,
    // external edge pins 1..13 at index 0..12, asynchronous
    input  wire logic [12:0] EXT_EDGE_PIN,
    // edge state and control outputs
    output logic             EDGE_A_FLAG,
    output logic             EDGE_B_FLAG,
    output logic             MODULE_ON,
    output logic             IDLE_STOP,
    output logic             DELAY_GEN_EN,
    output logic             SRC_GROUND,
    output logic             TRIG_ENABLE,
    output logic      [5:0]  CURRENT_TRIM,
    output logic      [1:0]  CURRENT_RANGE,
    // interrupt
    output logic             IRQ
);

    // synchronised asynchronous sources
    logic [15:0] async_in;
    logic [15:0] async_sync;
    logic        cmp1_s;
    logic        cmp2_s;
    logic        cmp3_s;
    logic [12:0] pin_s;

    // source vectors indexed by select code
    logic [15:0] src_a;
    logic [15:0] src_b;
    logic        a_hit;
    logic        b_hit;
    logic        a_ok;
    logic        b_ok;

    // registers
    logic [31:0]          ctl_reg;
    logic [31:0]          ctl_next;
    logic [1:0]           sts_reg;
    logic [1:0]           sts_next;
    logic [1:0]           msk_reg;
    logic [1:0]           msk_next;
    logic                 irq_reg;
    logic                 irq_next;
    logic                 bus_clk_phase_reg;
    logic                 bus_clk_phase_next;

    // bus slave state
    ctu_pkg::ctu_bus_t    bus_reg;
    ctu_pkg::ctu_bus_t    bus_next;
    logic [7:0]           addr_reg;
    logic [7:0]           addr_next;
    logic [31:0]          rdata_reg;
    logic [31:0]          rdata_next;
    logic                 ready_reg;
    logic                 ready_next;
    logic                 resp_reg;
    logic                 resp_next;
    logic                 accept;
    logic                 wr_ctl;
    logic                 wr_sts;
    logic                 wr_msk;

    assign async_in = {EXT_EDGE_PIN, CMP3_RESULT, CMP2_RESULT, CMP1_RESULT};

    ctu_sync2 #(
        .WIDTH (16)
    ) u_sync (
        .clk  (SYS_CLK),
        .rst  (SYS_RST),
        .din  (async_in),
        .dout (async_sync)
    );

    assign cmp1_s = async_sync[0];
    assign cmp2_s = async_sync[1];
    assign cmp3_s = async_sync[2];
    assign pin_s  = async_sync[15:3];

    // edge A source map
    always_comb begin
        src_a     = 16'h0000;
        src_a[15] = cmp3_s;
        src_a[14] = cmp2_s;
        src_a[13] = cmp1_s;
        src_a[12] = CAPTURE_UNIT_3_EVT;
        src_a[11] = CAPTURE_UNIT_2_EVT;
        src_a[10] = CAPTURE_UNIT_1_EVT;
        src_a[9]  = pin_s[7];
        src_a[8]  = pin_s[6];
        src_a[7]  = pin_s[5];
        src_a[6]  = pin_s[4];
        src_a[5]  = pin_s[3];
        src_a[4]  = pin_s[2];
        src_a[3]  = pin_s[0];
        src_a[2]  = pin_s[1];
        src_a[1]  = COMPARE_UNIT_1_EVT;
        src_a[0]  = FIRST_TIMER_EVENT;
    end

    // edge B source map; bus clock is modelled by a phase that flips each cycle
    always_comb begin
        src_b     = 16'h0000;
        src_b[15] = cmp3_s;
        src_b[14] = cmp2_s;
        src_b[13] = cmp1_s;
        src_b[12] = bus_clk_phase_reg;
        src_b[11] = CAPTURE_UNIT_3_EVT;
        src_b[10] = CAPTURE_UNIT_2_EVT;
        src_b[9]  = CAPTURE_UNIT_1_EVT;
        src_b[8]  = pin_s[12];
        src_b[7]  = pin_s[11];
        src_b[6]  = pin_s[10];
        src_b[5]  = pin_s[9];
        src_b[4]  = pin_s[8];
        src_b[3]  = pin_s[0];
        src_b[2]  = pin_s[1];
        src_b[1]  = COMPARE_UNIT_1_EVT;
        src_b[0]  = FIRST_TIMER_EVENT;
    end

    ctu_edge_unit #(
        .NSRC  (16),
        .SEL_W (4)
    ) u_edge_a (
        .clk  (SYS_CLK),
        .rst  (SYS_RST),
        .src  (src_a),
        .sel  (ctl_reg[ctu_pkg::A_SEL_HI:ctu_pkg::A_SEL_LO]),
        .mode (ctl_reg[ctu_pkg::A_MODE_BIT]),
        .pol  (ctl_reg[ctu_pkg::A_POL_BIT]),
        .hit  (a_hit)
    );

    ctu_edge_unit #(
        .NSRC  (16),
        .SEL_W (4)
    ) u_edge_b (
        .clk  (SYS_CLK),
        .rst  (SYS_RST),
        .src  (src_b),
        .sel  (ctl_reg[ctu_pkg::B_SEL_HI:ctu_pkg::B_SEL_LO]),
        .mode (ctl_reg[ctu_pkg::B_MODE_BIT]),
        .pol  (ctl_reg[ctu_pkg::B_POL_BIT]),
        .hit  (b_hit)
    );

    // edge gating and ordering
    always_comb begin
        a_ok = ctl_reg[ctu_pkg::PASS_BIT] && a_hit;
        b_ok = ctl_reg[ctu_pkg::PASS_BIT] && b_hit;
        // order check uses the flag as it stood, so same-cycle A and B drops B
        if (ctl_reg[ctu_pkg::ORDER_BIT] && !ctl_reg[ctu_pkg::A_FLAG_BIT]) begin
            b_ok = 1'b0;
        end
    end

    // bus address phase and write strobes
    always_comb begin
        // HSIZE is not decoded: every register is one whole word
        accept = HSEL && HREADY && HTRANS[1];
        wr_ctl = 1'b0;
        wr_sts = 1'b0;
        wr_msk = 1'b0;
        if (bus_reg == ctu_pkg::CTU_BUS_WRITE) begin
            if (addr_reg == ctu_pkg::CTL_OFS) begin
                wr_ctl = 1'b1;
            end else if (addr_reg == ctu_pkg::IRQ_STAT_OFS) begin
                wr_sts = 1'b1;
            end else if (addr_reg == ctu_pkg::IRQ_MASK_OFS) begin
                wr_msk = 1'b1;
            end
        end
    end

    // control register next state
    always_comb begin
        ctl_next = ctl_reg;
        if (wr_ctl) begin
            ctl_next = HWDATA & ctu_pkg::CTL_IMPL_MASK;
        end
        // hardware setting wins over a software write of zero
        if (a_ok) begin
            ctl_next[ctu_pkg::A_FLAG_BIT] = 1'b1;
        end
        if (b_ok) begin
            ctl_next[ctu_pkg::B_FLAG_BIT] = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            ctl_reg <= ctu_pkg::CTL_RST;
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    // interrupt status, mask and level output next state
    always_comb begin
        // status records only a flag going from clear to set, so a held level
        // raises one event; write one to clear, and a set in the same cycle wins
        sts_next = sts_reg;
        if (wr_sts) begin
            sts_next = sts_reg & ~HWDATA[ctu_pkg::IRQ_W-1:0];
        end
        if (a_ok && !ctl_reg[ctu_pkg::A_FLAG_BIT]) begin
            sts_next[ctu_pkg::EVT_A_IDX] = 1'b1;
        end
        if (b_ok && !ctl_reg[ctu_pkg::B_FLAG_BIT]) begin
            sts_next[ctu_pkg::EVT_B_IDX] = 1'b1;
        end

        msk_next = msk_reg;
        if (wr_msk) begin
            msk_next = HWDATA[ctu_pkg::IRQ_W-1:0];
        end

        // taken from the next values so the line moves with status and mask
        irq_next = |(sts_next & msk_next);
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            sts_reg <= ctu_pkg::IRQ_STAT_RST;
            msk_reg <= ctu_pkg::IRQ_MASK_RST;
            irq_reg <= 1'b0;
        end else begin
            sts_reg <= sts_next;
            msk_reg <= msk_next;
            irq_reg <= irq_next;
        end
    end

    // bus clock stand-in: a phase that flips every cycle
    always_comb begin
        bus_clk_phase_next = !bus_clk_phase_reg;
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            bus_clk_phase_reg <= 1'b0;
        end else begin
            bus_clk_phase_reg <= bus_clk_phase_next;
        end
    end

    // bus slave: writes take no wait state, reads one, so that read data
    // always comes from a flop and sees a write just before it
    always_comb begin
        bus_next   = ctu_pkg::CTU_BUS_IDLE;
        addr_next  = addr_reg;
        rdata_next = rdata_reg;
        ready_next = 1'b1;
        resp_next  = 1'b0;
        case (bus_reg)
            ctu_pkg::CTU_BUS_READ: begin
                if (addr_reg == ctu_pkg::CTL_OFS) begin
                    rdata_next = ctl_reg & ctu_pkg::CTL_IMPL_MASK;
                end else if (addr_reg == ctu_pkg::IRQ_STAT_OFS) begin
                    rdata_next = {30'h0000_0000, sts_reg};
                end else if (addr_reg == ctu_pkg::IRQ_MASK_OFS) begin
                    rdata_next = {30'h0000_0000, msk_reg};
                end else begin
                    rdata_next = 32'h0000_0000;
                end
            end
            default: begin
                if (accept) begin
                    addr_next = HADDR[7:0];
                    if (HWRITE) begin
                        bus_next = ctu_pkg::CTU_BUS_WRITE;
                    end else begin
                        bus_next   = ctu_pkg::CTU_BUS_READ;
                        ready_next = 1'b0;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            bus_reg   <= ctu_pkg::CTU_BUS_IDLE;
            addr_reg  <= 8'h00;
            rdata_reg <= ctu_pkg::RDATA_RST;
            ready_reg <= 1'b1;
            resp_reg  <= 1'b0;
        end else begin
            bus_reg   <= bus_next;
            addr_reg  <= addr_next;
            rdata_reg <= rdata_next;
            ready_reg <= ready_next;
            resp_reg  <= resp_next;
        end
    end

    // outputs straight from flops
    assign HRDATA        = rdata_reg;
    assign HREADYOUT     = ready_reg;
    assign HRESP         = resp_reg;
    assign EDGE_A_FLAG   = ctl_reg[ctu_pkg::A_FLAG_BIT];
    assign EDGE_B_FLAG   = ctl_reg[ctu_pkg::B_FLAG_BIT];
    assign MODULE_ON     = ctl_reg[ctu_pkg::ON_BIT];
    assign IDLE_STOP     = ctl_reg[ctu_pkg::IDLE_STOP_BIT];
    assign DELAY_GEN_EN  = ctl_reg[ctu_pkg::DELAY_GEN_BIT];
    assign SRC_GROUND    = ctl_reg[ctu_pkg::GROUND_BIT];
    assign TRIG_ENABLE   = ctl_reg[ctu_pkg::TRIG_BIT];
    assign CURRENT_TRIM  = ctl_reg[ctu_pkg::TRIM_HI:ctu_pkg::TRIM_LO];
    assign CURRENT_RANGE = ctl_reg[ctu_pkg::RANGE_HI:ctu_pkg::RANGE_LO];
    assign IRQ           = irq_reg;

endmodule // ctu_edge_ctrl

// ==== ctu_src_model.sv ====
`timescale 1ns/1ps
module ctu_src_model (
    // clock, reset and bench commands
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        set,
    input  wire logic [4:0]  sel,
    input  wire logic        lvl,
    // source lines towards the block
    output logic      [20:0] lines
);
    // on-chip events last one cycle; comparator results and pins hold their level
    localparam logic [20:0] PULSED = 21'h038003;
    always_ff @(posedge clk) begin
        if (rst) begin
            lines <= 21'h000000;
        end else begin
            lines <= lines & ~PULSED;
            if (set) begin
                lines[sel] <= lvl;
            end
        end
    end
endmodule // ctu_src_model

// ==== ctu_edge_ctrl_monitor.sv ====
`timescale 1ns/1ps
module ctu_edge_ctrl_mon (
    // clock, reset and bus
    input wire logic        SYS_CLK,
    input wire logic        SYS_RST,
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    // edge state, control copies, interrupt
    input wire logic        EDGE_A_FLAG,
    input wire logic        EDGE_B_FLAG,
    input wire logic        MODULE_ON,
    input wire logic [1:0]  CURRENT_RANGE,
    input wire logic        IRQ
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    logic ap;
    logic wc_reg, wm_reg, rd_reg, rc_reg, rv_reg, pass_reg, ord_reg;
    assign ap = HSEL && HREADY && HTRANS[1];
    // shadow of the gate bits, taken when a control write commits
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            {wc_reg, wm_reg, rd_reg, rc_reg, rv_reg, pass_reg, ord_reg} <= 7'h00;
        end else begin
            wc_reg <= ap && HWRITE && HADDR[7:0] == ctu_pkg::CTL_OFS;
            wm_reg <= ap && HWRITE && HADDR[7:0] == ctu_pkg::IRQ_MASK_OFS;
            rd_reg <= ap && !HWRITE;
            rc_reg <= ap && !HWRITE && HADDR[7:0] == ctu_pkg::CTL_OFS;
            rv_reg <= rc_reg;
            if (wc_reg) begin
                pass_reg <= HWDATA[ctu_pkg::PASS_BIT];
                ord_reg <= HWDATA[ctu_pkg::ORDER_BIT];
            end
        end
    end
    chk_read_wait: assert property (rd_reg |-> !HREADYOUT ##1 HREADYOUT)
        else $error("read data phase without exactly one wait");
    chk_unimpl_zero: assert property (rv_reg |-> HRDATA[17:16] == 2'h0 && !HRDATA[14])
        else $error("unimplemented control bits read nonzero");
    chk_flag_read: assert property (rv_reg |-> HRDATA[25:24] == $past({EDGE_B_FLAG, EDGE_A_FLAG}))
        else $error("flag bits read back differ from flag outputs");
    chk_a_clear: assert property ($fell(EDGE_A_FLAG) |-> $past(wc_reg) && !$past(HWDATA[24]))
        else $error("edge a flag dropped without a software write");
    chk_b_clear: assert property ($fell(EDGE_B_FLAG) |-> $past(wc_reg) && !$past(HWDATA[25]))
        else $error("edge b flag dropped without a software write");
    chk_a_gate: assert property ($rose(EDGE_A_FLAG) && !$past(wc_reg) |-> $past(pass_reg))
        else $error("edge a passed while edges blocked");
    chk_b_gate: assert property ($rose(EDGE_B_FLAG) && !$past(wc_reg) |-> $past(pass_reg))
        else $error("edge b passed while edges blocked");
    chk_order_seq: assert property ($rose(EDGE_B_FLAG) && !$past(wc_reg) && $past(ord_reg)
        |-> $past(EDGE_A_FLAG))
        else $error("edge b counted before edge a");
    chk_ctl_copy: assert property ($past(wc_reg)
        |-> MODULE_ON == $past(HWDATA[15]) && CURRENT_RANGE == $past(HWDATA[1:0]))
        else $error("control outputs do not follow written value");
    chk_irq_cause: assert property ($rose(IRQ)
        |-> $past(wm_reg) || $past(wm_reg, 2) || $rose(EDGE_A_FLAG) || $rose(EDGE_B_FLAG))
        else $error("interrupt rose without an edge or mask write");
    chk_resp_okay: assert property (HRESP == 1'b0)
        else $error("bus response not okay");
endmodule // ctu_edge_ctrl_mon

bind ctu_edge_ctrl ctu_edge_ctrl_mon i_ctu_edge_ctrl_mon (.SYS_CLK, .SYS_RST, .HSEL, .HADDR, .HTRANS,
    .HWRITE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .EDGE_A_FLAG, .EDGE_B_FLAG, .MODULE_ON,
    .CURRENT_RANGE, .IRQ);

// ==== test_ctu_edge_ctrl.sv ====
`timescale 1ns/1ps
module test_ctu_edge_ctrl;
    logic        SYS_CLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic        HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [1:0]  HTRANS = 2'h0;
    logic        HWRITE = 1'b0;
    logic [31:0] HWDATA = 32'h0;
    logic [31:0] HRDATA;
    logic        HREADYOUT, HRESP, EDGE_A_FLAG, EDGE_B_FLAG, IRQ;
    logic        MODULE_ON, IDLE_STOP, DELAY_GEN_EN, SRC_GROUND, TRIG_ENABLE;
    logic [5:0]  CURRENT_TRIM;
    logic [1:0]  CURRENT_RANGE;
    logic        s_set = 1'b0;
    logic [4:0]  s_sel = 5'h00;
    logic        s_lvl = 1'b0;
    logic [20:0] lines;
    int          err_total = 0;
    int          n_compared = 0;

    ctu_src_model i_ctu_src_model (.clk(SYS_CLK), .rst(SYS_RST), .set(s_set), .sel(s_sel), .lvl(s_lvl),
        .lines(lines));
    ctu_edge_ctrl i_ctu_edge_ctrl (.SYS_CLK, .SYS_RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2),
        .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP,
        .CMP1_RESULT(lines[18]), .CMP2_RESULT(lines[19]), .CMP3_RESULT(lines[20]),
        .CAPTURE_UNIT_1_EVT(lines[15]), .CAPTURE_UNIT_2_EVT(lines[16]), .CAPTURE_UNIT_3_EVT(lines[17]),
        .COMPARE_UNIT_1_EVT(lines[1]), .FIRST_TIMER_EVENT(lines[0]), .EXT_EDGE_PIN(lines[14:2]),
        .EDGE_A_FLAG, .EDGE_B_FLAG, .MODULE_ON, .IDLE_STOP, .DELAY_GEN_EN, .SRC_GROUND,
        .TRIG_ENABLE, .CURRENT_TRIM, .CURRENT_RANGE, .IRQ);

    initial begin
        forever #25 SYS_CLK = ~SYS_CLK;
    end

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic b, input logic e);
        chk({31'h0, b ? EDGE_B_FLAG : EDGE_A_FLAG}, {31'h0, e});
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask

    // the master waits for HREADYOUT after each phase; the watchdog ends a hang
    task automatic wait_rdy();
        @(posedge SYS_CLK);
        while (HREADYOUT !== 1'b1) begin
            @(posedge SYS_CLK);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {24'h0, a};
        wait_rdy();
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        wait_rdy();
        q = HRDATA;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    // second write clears a flag set by the select change itself
    task automatic cfgw(input logic [31:0] w);
        wr(ctu_pkg::CTL_OFS, w);
        idle(4);
        wr(ctu_pkg::CTL_OFS, w);
        idle(4);
    endtask

    task automatic src(input int i, input logic l);
        s_set <= 1'b1;
        s_sel <= i[4:0];
        s_lvl <= l;
        @(posedge SYS_CLK);
        s_set <= 1'b0;
        idle(5);
    endtask

    task automatic pulse(input int i);
        src(i, 1'b1);
        src(i, 1'b0);
    endtask

    function automatic int src_of(input logic b, input int c);
        if (c < 2) return c;
        if (c < 4) return 5 - c;
        if (!b) return (c < 10) ? c : c + 5;
        if (c == 12) return 31;
        return (c < 12) ? c + 6 : c + 5;
    endfunction

    // both sides default to rising edges of the timer event
    function automatic logic [31:0] cfg(input logic b, m, p, input int c, input logic pass, ord);
        logic [31:0] w;
        w = 32'hC0C0_0000;
        w[ctu_pkg::PASS_BIT] = pass;
        w[ctu_pkg::ORDER_BIT] = ord;
        if (b) begin
            w[ctu_pkg::B_MODE_BIT -: 6] = {m, p, c[3:0]};
        end else begin
            w[ctu_pkg::A_MODE_BIT -: 6] = {m, p, c[3:0]};
        end
        return w;
    endfunction

    task automatic t_regs();
        rd_chk(ctu_pkg::CTL_OFS, ctu_pkg::CTL_RST);
        rd_chk(ctu_pkg::IRQ_MASK_OFS, 32'h0);
        wr(8'h0C, 32'hFFFF_FFFF);
        rd_chk(8'h0C, 32'h0);
        wr(ctu_pkg::CTL_OFS, 32'hFFFF_FFFF);
        rd_chk(ctu_pkg::CTL_OFS, ctu_pkg::CTL_IMPL_MASK);
        chk({19'h0, MODULE_ON, IDLE_STOP, DELAY_GEN_EN, SRC_GROUND, TRIG_ENABLE, CURRENT_TRIM, CURRENT_RANGE},
            32'h1FFF);
        wr(ctu_pkg::CTL_OFS, 32'h0);
        rd_chk(ctu_pkg::CTL_OFS, 32'h0);
        $display("test registers done");
    endtask

    task automatic t_src(input logic b);
        int i;
        for (int c = 0; c < 16; c++) begin
            cfgw(cfg(b, 1'b1, 1'b1, c, 1'b1, 1'b0));
            i = src_of(b, (c + 1) % 16);
            if (i < 21 && src_of(b, c) < 21) begin
                pulse(i);
                chk_flag(b, 1'b0);
            end
            i = src_of(b, c);
            if (i < 21) begin
                pulse(i);
            end
            chk_flag(b, 1'b1);
        end
        $display("test sources of edge %0d done", b);
    endtask

    task automatic t_pol();
        cfgw(cfg(1'b0, 1'b1, 1'b0, 3, 1'b1, 1'b0));
        src(2, 1'b1);
        chk_flag(1'b0, 1'b0);
        src(2, 1'b0);
        chk_flag(1'b0, 1'b1);
        cfgw(cfg(1'b0, 1'b1, 1'b1, 3, 1'b1, 1'b0));
        src(2, 1'b1);
        chk_flag(1'b0, 1'b1);
        cfgw(cfg(1'b0, 1'b1, 1'b1, 3, 1'b1, 1'b0));
        chk_flag(1'b0, 1'b0);
        cfgw(cfg(1'b0, 1'b0, 1'b1, 3, 1'b1, 1'b0));
        chk_flag(1'b0, 1'b1);
        src(2, 1'b0);
        cfgw(cfg(1'b0, 1'b0, 1'b1, 3, 1'b1, 1'b0));
        chk_flag(1'b0, 1'b0);
        cfgw(cfg(1'b1, 1'b0, 1'b0, 3, 1'b1, 1'b0));
        chk_flag(1'b1, 1'b1);
        src(2, 1'b1);
        cfgw(cfg(1'b1, 1'b0, 1'b0, 3, 1'b1, 1'b0));
        chk_flag(1'b1, 1'b0);
        $display("test polarity and mode done");
    endtask

    task automatic t_gate();
        logic [31:0] w;
        cfgw(cfg(1'b0, 1'b1, 1'b1, 0, 1'b0, 1'b0));
        pulse(0);
        chk_flag(1'b0, 1'b0);
        chk_flag(1'b1, 1'b0);
        w = cfg(1'b1, 1'b1, 1'b1, 9, 1'b1, 1'b1);
        cfgw(w);
        pulse(15);
        chk_flag(1'b1, 1'b0);
        pulse(0);
        pulse(15);
        chk_flag(1'b1, 1'b1);
        w[ctu_pkg::ORDER_BIT] = 1'b0;
        cfgw(w);
        pulse(15);
        chk_flag(1'b1, 1'b1);
        $display("test gate and order done");
    endtask

    task automatic t_irq();
        cfgw(cfg(1'b0, 1'b1, 1'b1, 0, 1'b1, 1'b0));
        wr(ctu_pkg::IRQ_STAT_OFS, 32'h3);
        pulse(0);
        rd_chk(ctu_pkg::IRQ_STAT_OFS, 32'h3);
        chk({31'h0, IRQ}, 32'h0);
        wr(ctu_pkg::IRQ_MASK_OFS, 32'h2);
        idle(2);
        chk({31'h0, IRQ}, 32'h1);
        wr(ctu_pkg::IRQ_STAT_OFS, 32'h2);
        idle(2);
        chk({31'h0, IRQ}, 32'h0);
        rd_chk(ctu_pkg::IRQ_STAT_OFS, 32'h1);
        wr(ctu_pkg::IRQ_MASK_OFS, 32'h1);
        idle(2);
        chk({31'h0, IRQ}, 32'h1);
        wr(ctu_pkg::IRQ_STAT_OFS, 32'h1);
        wr(ctu_pkg::CTL_OFS, 32'h0300_0000);
        rd_chk(ctu_pkg::CTL_OFS, 32'h0300_0000);
        rd_chk(ctu_pkg::IRQ_STAT_OFS, 32'h0);
        chk({31'h0, IRQ}, 32'h0);
        $display("test interrupt done");
    endtask

    initial begin
        repeat (16) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        @(posedge SYS_CLK);
        t_regs();
        t_src(1'b0);
        t_src(1'b1);
        t_pol();
        t_gate();
        t_irq();
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge SYS_CLK);
        err_total++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_sim();
    end
endmodule // test_ctu_edge_ctrl
